// [common/nvm_port_params.svh]
// Contract
// - Control bit 24 shows memory write-in-progress; 0 means ready.
// - Bit 25 mirrors the memory write-latch flag.
// - Bits 27:26 hold block protect level: none, top quarter, half, all.
// - Bits 30:28 read 000b unless memory is in an internal write.
// - Bit 31 mirrors status-protect enable guarding the memory status register.
// - Dword address comes from control bits 12:0 (byte address / 4); the code also takes bit 20 as dword address bit 13.
// - Operation is decoded from command field bits 15:13.
// - Bits 19:16 are read-only; written values are ignored.
// - Data write/read never send mirrored bits 31:24 to the memory.
// - Clear-write-latch command sends the memory's write-disable instruction.
// - Each data access moves exactly four aligned bytes.
// - Data write programs the four buffer bytes at the addressed dword.
// - Read 6000h|addr fetches four bytes into the buffer.
// - Initial load checks CRC dword 78Fh; mismatch always flags error, as bypass bit 21 resets to 0 and cannot be written until the load ends.
// - Bits 19:18 show progress: done, busy, done with CRC error.
// - Command 101b reads memory status into bits 31:24.
// - Command 001b writes bits 31:24 into memory status; 000b and 111b start nothing.
`ifndef NVM_PORT_PARAMS_SVH
`define NVM_PORT_PARAMS_SVH

`define CTRL_OFS    12'h260
`define BUF_OFS     12'h264

`define F_ADDR      12:0
`define F_CMD       15:13
`define F_MIRROR    31:24
`define B_ADDR_HI   20
`define B_CRC_BYP   21

`define CMD_NOP     3'h0
`define CMD_WRSR    3'h1
`define CMD_WRITE   3'h2
`define CMD_READ    3'h3
`define CMD_WRDI    3'h4
`define CMD_FETCH   3'h5
`define CMD_WREN    3'h6
`define CMD_RSVD    3'h7

`define INS_WRSR    8'h01
`define INS_WRITE   8'h02
`define INS_READ    8'h03
`define INS_WRDI    8'h04
`define INS_FETCH   8'h05
`define INS_WREN    8'h06

`define BITS_INS    7'h08
`define BITS_SHORT  7'h10
`define BITS_LONG   7'h38

`define PROG_DONE   2'h0
`define PROG_BUSY   2'h1
`define PROG_CRCERR 2'h2
`define PRES_YES    2'h1
`define PRES_NO     2'h0

`define CRC_DWORD   13'h78F
`define CRC_POLY    32'h04C11DB7
`define CRC_INIT    32'hFFFFFFFF
`define BUF_RST     32'h00000000
`define MIRROR_RST  8'h00

`endif

// [common/nvm_port_pkg.sv]
package nvm_port_pkg;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_WAIT = 3'b100
    } core_state_t;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0001,
        PH_LOW  = 4'b0010,
        PH_HIGH = 4'b0100,
        PH_END  = 4'b1000
    } link_phase_t;

    typedef struct packed {
        logic [7:0]  instr;
        logic [15:0] addr;
        logic [31:0] wdata;
        logic [6:0]  nbits;
    } link_req_t;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
    } spi_out_t;

endpackage

// [hdl/nvm_spi_link.sv]
`timescale 1ns/10ps
`default_nettype none
`include "nvm_port_params.svh"

module nvm_spi_link
    import nvm_port_pkg::*;
(
    // link clock
    input  wire logic      spi_clk_i,
    // core side; req_i stays stable while a toggle is pending
    input  wire logic      core_rst_i,
    input  wire logic      req_tgl_i,
    input  wire link_req_t req_i,
    output logic           done_tgl_o,
    output logic [31:0]    rdata_o,
    // memory pins
    input  wire logic      miso_i,
    output spi_out_t       spi_o
);

    logic [2:0]  rst_s_q;
    logic        rst_q;
    logic [2:0]  req_s_q;
    logic        seen_q;
    link_phase_t ph_q;
    logic [55:0] sh_q;
    logic [6:0]  bitc_q;
    logic [31:0] rx_q;
    logic        first_q;

    // a toggle counts once the second and third stage agree
    wire req_new = (req_s_q[1] == req_s_q[2]) && (req_s_q[2] != seen_q);

    always_ff @(posedge spi_clk_i)
    begin
        rst_s_q <= {rst_s_q[1:0], core_rst_i};
        req_s_q <= {req_s_q[1:0], req_tgl_i};
        if (rst_s_q[1] == rst_s_q[2])
            rst_q <= rst_s_q[2];
    end

    // sck runs at half the link clock, mode 0: shift on low, sample after high
    always_ff @(posedge spi_clk_i)
    begin
        if (rst_q)
        begin
            ph_q       <= PH_IDLE;
            spi_o      <= '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            done_tgl_o <= 1'b0;
            seen_q     <= 1'b0;
            sh_q       <= '0;
            bitc_q     <= '0;
            rx_q       <= '0;
            rdata_o    <= '0;
            first_q    <= 1'b0;
        end
        else
        begin
            unique case (ph_q)
                PH_IDLE:
                    if (req_new)
                    begin
                        seen_q     <= req_s_q[2];
                        sh_q       <= {req_i.instr, req_i.addr, req_i.wdata};
                        bitc_q     <= req_i.nbits;
                        spi_o.cs_n <= 1'b0;
                        rx_q       <= '0;
                        first_q    <= 1'b1;
                        ph_q       <= PH_LOW;
                    end
                PH_LOW:
                begin
                    if (!first_q)
                        rx_q <= {rx_q[30:0], miso_i};
                    first_q   <= 1'b0;
                    spi_o.sck <= 1'b0;
                    if (bitc_q == 7'h00)
                        ph_q <= PH_END;
                    else
                    begin
                        spi_o.mosi <= sh_q[55];
                        sh_q       <= {sh_q[54:0], 1'b0};
                        bitc_q     <= bitc_q - 7'h01;
                        ph_q       <= PH_HIGH;
                    end
                end
                PH_HIGH:
                begin
                    spi_o.sck <= 1'b1;
                    ph_q      <= PH_LOW;
                end
                PH_END:
                begin
                    spi_o.cs_n <= 1'b1;
                    spi_o.mosi <= 1'b0;
                    rdata_o    <= rx_q;
                    done_tgl_o <= ~done_tgl_o;
                    ph_q       <= PH_IDLE;
                end
            endcase
        end
    end

endmodule // nvm_spi_link
`default_nettype wire

// [hdl/nvm_command_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "nvm_port_params.svh"

module nvm_command_port
    import nvm_port_pkg::*;
#(
    parameter logic [12:0] LOAD_LAST = `CRC_DWORD
)
(
    // core clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // serial link clock
    input  wire logic        spi_clk_i,
    // register port
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [11:0] reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // memory pins
    input  wire logic        present_n_i,
    input  wire logic        miso_i,
    output spi_out_t         spi_o
);

    core_state_t state_q;
    logic [2:0]  pres_s_q;
    logic        present_q;
    logic [2:0]  done_s_q;
    logic        done_seen_q;
    logic [12:0] addr_q;
    logic [2:0]  cmd_q;
    logic        addr_hi_q;
    logic        crc_byp_q;
    logic [1:0]  prog_q;
    logic [7:0]  mirror_q;
    logic [31:0] buf_q;
    logic        loading_q;
    logic [12:0] load_idx_q;
    logic [31:0] crc_q;
    logic        req_tgl_q;
    link_req_t   req_q;
    logic        done_tgl;
    logic [31:0] link_rdata;

    function automatic link_req_t build_req(
        input logic [2:0]  cmd,
        input logic [15:0] baddr,
        input logic [7:0]  status,
        input logic [31:0] data
    );
        link_req_t r;
        r = '0;
        case (cmd)
            `CMD_WRSR:
            begin
                r.instr = `INS_WRSR;
                r.addr  = {status, 8'h00};
                r.nbits = `BITS_SHORT;
            end
            `CMD_WRITE:
            begin
                r.instr = `INS_WRITE;
                r.addr  = baddr;
                r.wdata = {<<8{data}};
                r.nbits = `BITS_LONG;
            end
            `CMD_READ:
            begin
                r.instr = `INS_READ;
                r.addr  = baddr;
                r.nbits = `BITS_LONG;
            end
            `CMD_FETCH:
            begin
                r.instr = `INS_FETCH;
                r.nbits = `BITS_SHORT;
            end
            `CMD_WREN:
            begin
                r.instr = `INS_WREN;
                r.nbits = `BITS_INS;
            end
            default:
            begin
                r.instr = `INS_WRDI;
                r.nbits = `BITS_INS;
            end
        endcase
        return r;
    endfunction

    function automatic logic [31:0] crc_step(input logic [31:0] crc, input logic [31:0] d);
        logic [31:0] c;
        logic        fb;
        c = crc;
        for (int i = 31; i >= 0; i--)
        begin
            fb = c[31] ^ d[i];
            c  = {c[30:0], 1'b0} ^ (fb ? `CRC_POLY : 32'h00000000);
        end
        return c;
    endfunction

    // decode
    wire        sel_ctrl   = reg_addr_i == `CTRL_OFS;
    wire        sel_buf    = reg_addr_i == `BUF_OFS;
    wire        idle       = state_q == ST_IDLE;
    // writes during an operation are dropped; the request words must not move
    wire        wr_ctrl    = reg_wr_i && sel_ctrl && idle;
    wire        wr_buf     = reg_wr_i && sel_buf && idle;
    wire [2:0]  wr_cmd     = reg_wdata_i[`F_CMD];
    wire        cmd_valid  = (wr_cmd != `CMD_NOP) && (wr_cmd != `CMD_RSVD);
    wire        start_sw   = wr_ctrl && cmd_valid && present_q;
    wire [15:0] sw_baddr   = {reg_wdata_i[`B_ADDR_HI], reg_wdata_i[`F_ADDR], 2'b00};
    wire        pres_ok    = pres_s_q[1] == pres_s_q[2];
    wire        boot_go    = (state_q == ST_BOOT) && pres_ok;
    wire        boot_load  = boot_go && pres_s_q[2];
    wire        done_evt   = (done_s_q[1] == done_s_q[2]) && (done_s_q[2] != done_seen_q);
    wire        load_done  = done_evt && loading_q;
    wire        sw_done    = done_evt && !loading_q;
    wire        load_end   = load_idx_q == LOAD_LAST;
    wire        load_more  = load_done && !load_end;
    wire        issue      = start_sw || boot_load || load_more;
    wire [12:0] load_next  = boot_load ? '0 : 13'(load_idx_q + 13'h0001);
    wire        crc_ok     = (crc_q == link_rdata) || crc_byp_q;
    wire [31:0] rd_swapped = {<<8{link_rdata}};
    wire [1:0]  pres_code  = present_q ? `PRES_YES : `PRES_NO;
    wire link_req_t sw_req = build_req(wr_cmd, sw_baddr, reg_wdata_i[`F_MIRROR], buf_q);
    wire link_req_t ld_req = build_req(`CMD_READ, {1'b0, load_next, 2'b00}, '0, '0);
    // bits 23:22 read zero; 17:16 report presence
    wire [31:0] ctrl_view  = {mirror_q, 2'b00, crc_byp_q, addr_hi_q,
                              prog_q, pres_code, cmd_q, addr_q};
    wire [31:0] rd_mux     = sel_ctrl ? ctrl_view : (sel_buf ? buf_q : '0);

    // presence strap and link completion cross in on three flops
    always_ff @(posedge clk_i)
    begin
        pres_s_q <= {pres_s_q[1:0], ~present_n_i};
        done_s_q <= {done_s_q[1:0], done_tgl};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            present_q   <= 1'b0;
            done_seen_q <= 1'b0;
        end
        else
        begin
            if (pres_ok)
                present_q <= pres_s_q[2];
            if (done_evt)
                done_seen_q <= done_s_q[2];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            state_q <= ST_BOOT;
        else
        begin
            unique case (state_q)
                ST_BOOT:
                    if (boot_go)
                        state_q <= pres_s_q[2] ? ST_WAIT : ST_IDLE;
                ST_IDLE:
                    if (start_sw)
                        state_q <= ST_WAIT;
                ST_WAIT:
                    if (done_evt && !load_more)
                        state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            req_tgl_q <= 1'b0;
            req_q     <= '0;
        end
        else if (issue)
        begin
            req_tgl_q <= ~req_tgl_q;
            req_q     <= start_sw ? sw_req : ld_req;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            loading_q  <= 1'b0;
            load_idx_q <= '0;
            crc_q      <= `CRC_INIT;
        end
        else if (boot_load)
        begin
            loading_q  <= 1'b1;
            load_idx_q <= '0;
            crc_q      <= `CRC_INIT;
        end
        else if (load_done)
        begin
            loading_q  <= !load_end;
            load_idx_q <= load_next;
            crc_q      <= load_end ? crc_q : crc_step(crc_q, link_rdata);
        end
    end

    // progress: busy from acceptance until the link reports the end
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            prog_q <= `PROG_DONE;
        else if (start_sw || boot_load)
            prog_q <= `PROG_BUSY;
        else if (load_done && load_end)
            prog_q <= crc_ok ? `PROG_DONE : `PROG_CRCERR;
        else if (sw_done)
            prog_q <= `PROG_DONE;
    end

    // bits 19:16 have no write path
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            addr_q    <= '0;
            cmd_q     <= `CMD_NOP;
            addr_hi_q <= 1'b0;
            crc_byp_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            addr_q    <= reg_wdata_i[`F_ADDR];
            cmd_q     <= wr_cmd;
            addr_hi_q <= reg_wdata_i[`B_ADDR_HI];
            crc_byp_q <= reg_wdata_i[`B_CRC_BYP];
        end
    end

    // the mirror only takes written bits on a status write, so data
    // commands whatever their upper half keep the last fetched status
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            mirror_q <= `MIRROR_RST;
        else if (wr_ctrl && wr_cmd == `CMD_WRSR)
            mirror_q <= reg_wdata_i[`F_MIRROR];
        else if (sw_done && cmd_q == `CMD_FETCH)
            mirror_q <= link_rdata[7:0];
    end

    // byte 0 of the buffer is the lowest memory address
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            buf_q <= `BUF_RST;
        else if (wr_buf)
            buf_q <= reg_wdata_i;
        else if (sw_done && cmd_q == `CMD_READ)
            buf_q <= rd_swapped;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            reg_rdata_o <= '0;
        else if (reg_rd_i)
            reg_rdata_o <= rd_mux;
    end

    nvm_spi_link u_link (
        .spi_clk_i  (spi_clk_i),
        .core_rst_i (srst_i),
        .req_tgl_i  (req_tgl_q),
        .req_i      (req_q),
        .done_tgl_o (done_tgl),
        .rdata_o    (link_rdata),
        .miso_i     (miso_i),
        .spi_o      (spi_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    property p_busy_on_accept;
        start_sw |=> prog_q == `PROG_BUSY ##1 (prog_q == `PROG_BUSY) [*2];
    endproperty
    a_busy_on_accept: assert property (p_busy_on_accept)
        else $error("progress not busy after command accept");

    property p_write_disable;
        start_sw && wr_cmd == `CMD_WRDI |=> req_q.instr == `INS_WRDI && req_q.nbits == `BITS_INS;
    endproperty
    a_write_disable: assert property (p_write_disable)
        else $error("write-disable command did not send its instruction");

    property p_data_no_status;
        start_sw && (wr_cmd == `CMD_WRITE || wr_cmd == `CMD_READ) |=> $stable(mirror_q);
    endproperty
    a_data_no_status: assert property (p_data_no_status)
        else $error("data command disturbed the status mirror");

    property p_write_four_bytes;
        start_sw && wr_cmd == `CMD_WRITE
            |=> req_q.nbits == `BITS_LONG
                && req_q.wdata == {$past(buf_q[7:0]), $past(buf_q[15:8]),
                                   $past(buf_q[23:16]), $past(buf_q[31:24])};
    endproperty
    a_write_four_bytes: assert property (p_write_four_bytes)
        else $error("data write request does not carry the buffer");

    property p_read_address;
        start_sw && wr_cmd == `CMD_READ
            |=> req_q.instr == `INS_READ && req_q.addr[14:2] == addr_q;
    endproperty
    a_read_address: assert property (p_read_address)
        else $error("read request address differs from the address field");

    property p_status_fetch;
        sw_done && cmd_q == `CMD_FETCH |=> mirror_q == $past(link_rdata[7:0]);
    endproperty
    a_status_fetch: assert property (p_status_fetch)
        else $error("status fetch did not update the mirror");

    property p_crc_error;
        load_done && load_end && !crc_ok |=> prog_q == `PROG_CRCERR ##1 prog_q == `PROG_CRCERR;
    endproperty
    a_crc_error: assert property (p_crc_error)
        else $error("CRC mismatch not reported");

    property p_ctrl_readback;
        reg_rd_i && sel_ctrl |=> reg_rdata_o[31:24] == $past(mirror_q)
            && reg_rdata_o[19:18] == $past(prog_q) && reg_rdata_o[23:22] == 2'b00;
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control register read back wrong");

    property p_ro_bits;
        wr_ctrl && !cmd_valid |=> $stable(prog_q);
    endproperty
    a_ro_bits: assert property (p_ro_bits)
        else $error("write changed read-only progress bits");

endmodule // nvm_command_port
`default_nettype wire

// [bench/nvm_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none

module nvm_mem_model
(
    // serial pins
    input  wire logic cs_n_i,
    input  wire logic sck_i,
    input  wire logic mosi_i,
    output logic      miso_o
);
    logic [7:0]  mem [0:255];
    logic [7:0]  stat;
    logic [7:0]  ins;
    logic [15:0] adr;
    logic [31:0] sh;
    logic        dout;
    int          n;

    initial
    begin
        stat = 8'h00;
        dout = 1'b0;
        n    = 0;
        foreach (mem[i]) mem[i] = 8'h00;
    end

    // released line shows the inverse so a stale bit is never taken as data
    assign miso_o = cs_n_i ? ~dout : dout;

    always @(negedge cs_n_i) n = 0;

    // status and data writes drop the write latch when the frame closes
    always @(posedge cs_n_i)
        if (ins == 8'h01 || ins == 8'h02) stat[1] = 1'b0;

    always @(posedge sck_i)
        if (!cs_n_i)
        begin
            sh = {sh[30:0], mosi_i};
            n  = n + 1;
            if (n == 8)
            begin
                ins = sh[7:0];
                if (ins == 8'h06) stat[1] = 1'b1;
                if (ins == 8'h04) stat[1] = 1'b0;
            end
            if (n == 16 && ins == 8'h01 && stat[1]) stat = {sh[7], 3'h0, sh[3:2], stat[1:0]};
            if (n == 24) adr = sh[15:0];
            if (n > 24 && n % 8 == 0 && ins == 8'h02 && stat[1])
                mem[8'(adr[7:0] + (n - 32) / 8)] = sh[7:0];
        end

    always @(negedge sck_i)
        if (!cs_n_i)
        begin
            if (ins == 8'h05 && n >= 8) dout = stat[7 - (n - 8) % 8];
            if (ins == 8'h03 && n >= 24) dout = mem[8'(adr[7:0] + (n - 24) / 8)][7 - (n - 24) % 8];
        end
endmodule // nvm_mem_model

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/10ps
`default_nettype none

module tb
    import nvm_port_pkg::*;
;
    logic        clk_i;
    logic        srst_i;
    logic        spi_clk_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [11:0] reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic [31:0] reg_rdata_o;
    logic        present_n_i;
    wire logic   miso;
    spi_out_t    spi;
    int          miscompares;
    int          tests_run;
    int          cs_cnt;
    int          nbits;

    initial clk_i = 1'b0;
    always #20 clk_i = ~clk_i;

    // half period of 32 never lands on a core rising edge or a stimulus step
    initial spi_clk_i = 1'b0;
    always #32 spi_clk_i = ~spi_clk_i;

    // short load keeps boot time small
    nvm_command_port #(.LOAD_LAST(13'h003)) dut (
        .clk_i       (clk_i),
        .srst_i      (srst_i),
        .spi_clk_i   (spi_clk_i),
        .reg_wr_i    (reg_wr_i),
        .reg_rd_i    (reg_rd_i),
        .reg_addr_i  (reg_addr_i),
        .reg_wdata_i (reg_wdata_i),
        .reg_rdata_o (reg_rdata_o),
        .present_n_i (present_n_i),
        .miso_i      (miso),
        .spi_o       (spi)
    );

    nvm_mem_model mem_u (
        .cs_n_i (spi.cs_n),
        .sck_i  (spi.sck),
        .mosi_i (spi.mosi),
        .miso_o (miso)
    );

    always @(negedge spi.cs_n)
    begin
        nbits  = 0;
        cs_cnt = cs_cnt + 1;
    end

    always @(posedge spi.sck)
        if (!spi.cs_n) nbits = nbits + 1;

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic do_reset(input logic absent);
        @(posedge clk_i);
        #1;
        srst_i      = 1'b1;
        present_n_i = absent;
        repeat (20) @(posedge clk_i);
        #1;
        srst_i = 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        #1;
        reg_wr_i    = 1'b1;
        reg_addr_i  = a;
        reg_wdata_i = d;
        @(posedge clk_i);
        #1;
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk_i);
        #1;
        reg_rd_i   = 1'b1;
        reg_addr_i = a;
        @(posedge clk_i);
        #1;
        reg_rd_i = 1'b0;
        @(posedge clk_i);
        #1;
        d = reg_rdata_o;
    endtask

    task automatic poll(output logic [31:0] r);
        int k;
        k = 0;
        rd(12'h260, r);
        while (r[19:18] === 2'h1 && k < 3000)
        begin
            rd(12'h260, r);
            k = k + 1;
        end
        check(32'(k < 3000), 32'h1, "operation ends in time");
    endtask

    // one command write, then wait for completion; bits 0 means no frame expected
    task automatic cmd(input logic [31:0] v, input int bits, output logic [31:0] r);
        int c0;
        c0 = cs_cnt;
        wr(12'h260, v);
        rd(12'h260, r);
        if (bits > 0)
            check(32'(r[19:18]), 32'h1, "busy after command");
        poll(r);
        check(32'(r[19:18]), 32'h0, "progress complete");
        check(32'(cs_cnt - c0), 32'(bits > 0), "frame count");
        if (bits > 0)
            check(32'(nbits), 32'(bits), "frame length");
    endtask

    task automatic t_boot;
        logic [31:0] r;
        repeat (8) @(posedge clk_i);
        poll(r);
        check(32'(r[19:18]), 32'h2, "boot crc error");
        check(32'(r[17:16]), 32'h1, "present");
        check(32'(r[31:24]), 32'h0, "mirror reset");
        rd(12'h264, r);
        check(r, 32'h0, "buffer reset");
        rd(12'h268, r);
        check(r, 32'h0, "unmapped read");
        $display("test boot done");
    endtask

    task automatic t_latch;
        logic [31:0] r;
        cmd(32'h0000C000, 8, r);
        cmd(32'h0000A000, 16, r);
        check(32'(r[31:24]), 32'h02, "latch set");
        cmd(32'h00008000, 8, r);
        cmd(32'h0000A000, 16, r);
        check(32'(r[31:24]), 32'h00, "latch cleared");
        $display("test latch done");
    endtask

    task automatic t_fields;
        logic [31:0] r;
        cmd(32'h001F1ABC, 0, r);
        check(r, 32'h00111ABC, "field readback");
        cmd(32'h0000E000, 0, r);
        $display("test fields done");
    endtask

    task automatic t_status;
        logic [7:0]  sv [5];
        logic [31:0] r;
        sv = '{8'h04, 8'h08, 8'h0C, 8'h8C, 8'h00};
        for (int i = 0; i < 5; i++)
        begin
            cmd(32'h0000C000, 8, r);
            cmd({sv[i], 24'h002000}, 16, r);
            cmd(32'h0000A000, 16, r);
            check(32'(r[31:24]), 32'(sv[i]), "fetched status");
            check(32'(r[30:28]), 32'h0, "write state idle");
            check(32'(r[24]), 32'h0, "memory ready");
        end
        $display("test status done");
    endtask

    task automatic t_data;
        logic [31:0] r;
        wr(12'h264, 32'hA1B2C3D4);
        cmd(32'h0000C000, 8, r);
        cmd(32'hFF004005, 56, r);
        check(32'(r[31:24]), 32'h0, "mirror kept on data write");
        cmd(32'h00008000, 8, r);
        wr(12'h264, 32'h0);
        cmd(32'h00006005, 56, r);
        rd(12'h264, r);
        check(r, 32'hA1B2C3D4, "data read back");
        cmd(32'h00006006, 56, r);
        rd(12'h264, r);
        check(r, 32'h0, "next dword untouched");
        cmd(32'h0000A000, 16, r);
        check(32'(r[31:24]), 32'h0, "memory status untouched");
        $display("test data done");
    endtask

    task automatic t_absent;
        logic [31:0] r;
        do_reset(1'b1);
        repeat (8) @(posedge clk_i);
        rd(12'h260, r);
        check(32'(r[19:16]), 32'h0, "absent status");
        cmd(32'h0000C000, 0, r);
        $display("test absent done");
    endtask

    initial
    begin
        srst_i      = 1'b1;
        reg_wr_i    = 1'b0;
        reg_rd_i    = 1'b0;
        reg_addr_i  = 12'h000;
        reg_wdata_i = 32'h0;
        present_n_i = 1'b0;
        miscompares = 0;
        tests_run   = 0;
        cs_cnt      = 0;
        nbits       = 0;
        do_reset(1'b0);
        t_boot;
        t_latch;
        t_fields;
        t_status;
        t_data;
        t_absent;
        stop_test;
    end

    // about nine times the expected run
    initial
    begin
        #1000000;
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t watchdog expired", $time);
        stop_test;
    end
endmodule // tb

`default_nettype wire
